// ---- ahp_pkg.sv ----
package ahp_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int BYTE_W = 8;

  // ****************************************
  // Timing, in ns, and derived cycle counts at 100 MHz
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PIO_ACTIVE_NS = 80;
  localparam int PIO_RECOVER_NS = 70;
  localparam int DMA_ACTIVE_NS = 60;
  localparam int DMA_RECOVER_NS = 30;
  localparam int PIO_ACTIVE_CYC = (PIO_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIO_RECOVER_CYC = (PIO_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DMA_ACTIVE_CYC = (DMA_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DMA_RECOVER_CYC = (DMA_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ****************************************
  // Access kinds and states
  // ****************************************
  typedef enum logic [1:0] {
    AHP_KIND_REG = 2'b00,
    AHP_KIND_PIO_DATA = 2'b01,
    AHP_KIND_DMA = 2'b10
  } ahp_kind_t;

  typedef enum logic [2:0] {
    AHP_IDLE = 3'b000,
    AHP_SETUP = 3'b001,
    AHP_ACTIVE = 3'b010,
    AHP_WAIT = 3'b011,
    AHP_RECOVER = 3'b100
  } ahp_state_t;
endpackage

// ---- ahp_ata_host_channel_port.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Register accesses use data bits 7..0 only
// - Sector data moves as 16-bit words
// - Bit 0 even byte, bit 8 odd byte
// - Acknowledge only after DMA request seen; then held until recovery
// - Host captures read data at strobe rise
// - Not-ready line stretches register and PIO strobes, not DMA
// - Three-bit register address plus chip select
// - Upper card address lines held low
// - Cable sense picks allowed DMA mode
// - Chip selects pick command or control block
// - Drive reset is inverted system reset
// - High enable addresses odd byte on word transfers only
// - Two drives per channel, master and slave
module ahp_ata_host_channel_port
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic systemBusReset,
  // Primary channel request
  input wire logic priReqValid,
  output logic priReqReady,
  input wire logic priReqWrite,
  input wire ahp_pkg::ahp_kind_t priReqKind,
  input wire logic priReqControlBlock,
  input wire logic [ahp_pkg::ADDR_W-1:0] priReqAddr,
  input wire logic [ahp_pkg::DATA_W-1:0] priReqData,
  input wire logic priUltraDmaWanted,
  output logic priRspValid,
  output logic [ahp_pkg::DATA_W-1:0] priRspData,
  output logic priFastDmaAllowed,
  output logic priIrqOut,
  // Secondary channel request
  input wire logic secReqValid,
  output logic secReqReady,
  input wire logic secReqWrite,
  input wire ahp_pkg::ahp_kind_t secReqKind,
  input wire logic secReqControlBlock,
  input wire logic [ahp_pkg::ADDR_W-1:0] secReqAddr,
  input wire logic [ahp_pkg::DATA_W-1:0] secReqData,
  input wire logic secUltraDmaWanted,
  output logic secRspValid,
  output logic [ahp_pkg::DATA_W-1:0] secRspData,
  output logic secFastDmaAllowed,
  output logic secIrqOut,
  // Primary disk pins
  input wire logic [ahp_pkg::DATA_W-1:0] primaryDiskDataBusIn,
  output logic [ahp_pkg::DATA_W-1:0] primaryDiskDataBusOut,
  output logic primaryDiskDataBusOe_b,
  output logic [ahp_pkg::ADDR_W-1:0] primaryRegisterSelect,
  output logic primaryCommandBlockSelect_b,
  output logic primaryControlBlockSelect_b,
  output logic primaryReadStrobe_b,
  output logic primaryWriteStrobe_b,
  input wire logic primaryChannelReady,
  input wire logic primaryDmaRequest,
  output logic primaryDmaAck_b,
  input wire logic primaryCableSense,
  input wire logic primaryIrq14,
  output logic cardEnableLow_b,
  output logic cardEnableHigh_b,
  output logic [ahp_pkg::ADDR_W-1:0] cardUpperAddr,
  // Secondary disk pins
  input wire logic [ahp_pkg::DATA_W-1:0] secondaryDiskDataBusIn,
  output logic [ahp_pkg::DATA_W-1:0] secondaryDiskDataBusOut,
  output logic secondaryDiskDataBusOe_b,
  output logic [ahp_pkg::ADDR_W-1:0] secondaryRegisterSelect,
  output logic secondaryCommandBlockSelect_b,
  output logic secondaryControlBlockSelect_b,
  output logic secondaryReadStrobe_b,
  output logic secondaryWriteStrobe_b,
  input wire logic secondaryChannelReady,
  input wire logic secondaryDmaRequest,
  output logic secondaryDmaAck_b,
  input wire logic secondaryCableSense,
  input wire logic secondaryIrq15,
  // Shared
  output logic driveReset_b
);
  import ahp_pkg::*;

  // ****************************************
  // Shared reset to both cables
  // ****************************************
  // Straight inversion, no state, so it tracks the bus reset instantly
  assign driveReset_b = ~systemBusReset;
  // Card has no extra address lines wired; tie them low
  assign cardUpperAddr = '0;

  // ****************************************
  // Card enables follow the primary command or control select and strobes
  // ****************************************
  // High enable only ever reaches the odd byte, so it joins word transfers
  logic cardWordActive;
  assign cardEnableLow_b = primaryCommandBlockSelect_b & primaryControlBlockSelect_b;
  assign cardEnableHigh_b = (primaryReadStrobe_b & primaryWriteStrobe_b) | ~cardWordActive;

  // ****************************************
  // One engine per channel
  // ****************************************
  // Both drives of a cable share these pins; a register write picks one
  ahp_channel_engine uPri (
    .clock(clock), .rst_b(rst_b),
    .reqValid(priReqValid), .reqReady(priReqReady), .reqWrite(priReqWrite),
    .reqKind(priReqKind), .reqControlBlock(priReqControlBlock), .reqAddr(priReqAddr),
    .reqData(priReqData), .ultraDmaWanted(priUltraDmaWanted),
    .rspValid(priRspValid), .rspData(priRspData), .fastDmaAllowed(priFastDmaAllowed),
    .irqOut(priIrqOut), .wordActive(cardWordActive),
    .busIn(primaryDiskDataBusIn), .busOut(primaryDiskDataBusOut), .busOe_b(primaryDiskDataBusOe_b),
    .regSel(primaryRegisterSelect), .cmdSel_b(primaryCommandBlockSelect_b),
    .ctlSel_b(primaryControlBlockSelect_b), .rdStrobe_b(primaryReadStrobe_b),
    .wrStrobe_b(primaryWriteStrobe_b), .chanReady(primaryChannelReady),
    .dmaReq(primaryDmaRequest), .dmaAck_b(primaryDmaAck_b),
    .cableSense(primaryCableSense), .irqIn(primaryIrq14)
  );

  ahp_channel_engine uSec (
    .clock(clock), .rst_b(rst_b),
    .reqValid(secReqValid), .reqReady(secReqReady), .reqWrite(secReqWrite),
    .reqKind(secReqKind), .reqControlBlock(secReqControlBlock), .reqAddr(secReqAddr),
    .reqData(secReqData), .ultraDmaWanted(secUltraDmaWanted),
    .rspValid(secRspValid), .rspData(secRspData), .fastDmaAllowed(secFastDmaAllowed),
    .irqOut(secIrqOut), .wordActive(),
    .busIn(secondaryDiskDataBusIn), .busOut(secondaryDiskDataBusOut), .busOe_b(secondaryDiskDataBusOe_b),
    .regSel(secondaryRegisterSelect), .cmdSel_b(secondaryCommandBlockSelect_b),
    .ctlSel_b(secondaryControlBlockSelect_b), .rdStrobe_b(secondaryReadStrobe_b),
    .wrStrobe_b(secondaryWriteStrobe_b), .chanReady(secondaryChannelReady),
    .dmaReq(secondaryDmaRequest), .dmaAck_b(secondaryDmaAck_b),
    .cableSense(secondaryCableSense), .irqIn(secondaryIrq15)
  );
endmodule

// ****************************************
// Per-channel cycle engine
// ****************************************
module ahp_channel_engine
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // User request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire ahp_pkg::ahp_kind_t reqKind,
  input wire logic reqControlBlock,
  input wire logic [ahp_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [ahp_pkg::DATA_W-1:0] reqData,
  input wire logic ultraDmaWanted,
  output logic rspValid,
  output logic [ahp_pkg::DATA_W-1:0] rspData,
  output logic fastDmaAllowed,
  output logic irqOut,
  output logic wordActive,
  // Cable pins
  input wire logic [ahp_pkg::DATA_W-1:0] busIn,
  output logic [ahp_pkg::DATA_W-1:0] busOut,
  output logic busOe_b,
  output logic [ahp_pkg::ADDR_W-1:0] regSel,
  output logic cmdSel_b,
  output logic ctlSel_b,
  output logic rdStrobe_b,
  output logic wrStrobe_b,
  input wire logic chanReady,
  input wire logic dmaReq,
  output logic dmaAck_b,
  input wire logic cableSense,
  input wire logic irqIn
);
  import ahp_pkg::*;

  ahp_state_t state;
  ahp_kind_t kind;
  logic isWrite;
  logic [CNT_W-1:0] count;

  // Active and recovery length per access kind
  function automatic logic [CNT_W-1:0] activeLen(input ahp_kind_t k);
    activeLen = (k == AHP_KIND_DMA) ? CNT_W'(DMA_ACTIVE_CYC) : CNT_W'(PIO_ACTIVE_CYC);
  endfunction
  function automatic logic [CNT_W-1:0] recoverLen(input ahp_kind_t k);
    recoverLen = (k == AHP_KIND_DMA) ? CNT_W'(DMA_RECOVER_CYC) : CNT_W'(PIO_RECOVER_CYC);
  endfunction

  // A DMA request waits for the drive's request; others start at once
  assign reqReady = (state == AHP_IDLE) & ((reqKind != AHP_KIND_DMA) | dmaReq);
  assign wordActive = (state != AHP_IDLE) & (kind != AHP_KIND_REG);
  // Pass the drive's line straight through; the drive owns its meaning
  assign irqOut = irqIn;
  // Ultra modes need the 80-wire cable; without it only slow DMA
  assign fastDmaAllowed = ultraDmaWanted & cableSense;

  // Cycle sequencing, strobes and captured data
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= AHP_IDLE;
      kind <= AHP_KIND_REG;
      isWrite <= 1'b0;
      count <= '0;
      regSel <= '0;
      cmdSel_b <= 1'b1;
      ctlSel_b <= 1'b1;
      rdStrobe_b <= 1'b1;
      wrStrobe_b <= 1'b1;
      dmaAck_b <= 1'b1;
      busOut <= DATA_RST;
      busOe_b <= 1'b1;
      rspValid <= 1'b0;
      rspData <= DATA_RST;
    end
    else
    begin
      rspValid <= 1'b0;
      case (state)
        AHP_IDLE:
        begin
          if (reqValid && reqReady)
          begin
            kind <= reqKind;
            isWrite <= reqWrite;
            dmaAck_b <= (reqKind != AHP_KIND_DMA);
            if (reqKind != AHP_KIND_DMA)
            begin
              regSel <= reqAddr;
              cmdSel_b <= reqControlBlock;
              ctlSel_b <= ~reqControlBlock;
            end
            // Register bytes ride bits 7..0 only; words use the full bus
            busOut <= (reqKind == AHP_KIND_REG) ? {8'h00, reqData[BYTE_W-1:0]} : reqData;
            busOe_b <= ~reqWrite;
            state <= AHP_SETUP;
          end
        end
        AHP_SETUP:
        begin
          // Strobe falls one cycle after address and select settle
          rdStrobe_b <= isWrite;
          wrStrobe_b <= ~isWrite;
          count <= activeLen(kind);
          state <= AHP_ACTIVE;
        end
        AHP_ACTIVE:
        begin
          count <= count - CNT_W'(1);
          if (count < CNT_W'(2))
          begin
            state <= AHP_WAIT;
          end
        end
        AHP_WAIT:
        begin
          // Not-ready drive holds a register or PIO strobe low until it lets go; DMA ignores it
          if (chanReady || kind == AHP_KIND_DMA)
          begin
            rdStrobe_b <= 1'b1;
            wrStrobe_b <= 1'b1;
            if (!isWrite)
            begin
              // Sampled at the same edge the read strobe rises
              rspData <= (kind == AHP_KIND_REG) ? {8'h00, busIn[BYTE_W-1:0]} : busIn;
              rspValid <= 1'b1;
            end
            count <= recoverLen(kind);
            state <= AHP_RECOVER;
          end
        end
        AHP_RECOVER:
        begin
          busOe_b <= 1'b1;
          dmaAck_b <= 1'b1;
          cmdSel_b <= 1'b1;
          ctlSel_b <= 1'b1;
          count <= count - CNT_W'(1);
          if (count < CNT_W'(2))
          begin
            state <= AHP_IDLE;
          end
        end
        default:
        begin
          state <= AHP_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- ahp_host_port_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Primary channel pin checker
// ****************************************
module ahp_host_port_checker
  import ahp_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rst_b,
  input wire logic systemBusReset,
  input wire logic driveReset_b,
  // User side
  input wire logic priRspValid,
  input wire logic [ahp_pkg::DATA_W-1:0] priRspData,
  input wire logic priUltraDmaWanted,
  input wire logic priFastDmaAllowed,
  input wire logic priIrqOut,
  // Cable side
  input wire logic [ahp_pkg::DATA_W-1:0] primaryDiskDataBusIn,
  input wire logic primaryDiskDataBusOe_b,
  input wire logic primaryReadStrobe_b,
  input wire logic primaryWriteStrobe_b,
  input wire logic primaryChannelReady,
  input wire logic primaryDmaRequest,
  input wire logic primaryDmaAck_b,
  input wire logic primaryCableSense,
  input wire logic primaryIrq14,
  input wire logic [ahp_pkg::ADDR_W-1:0] cardUpperAddr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_rst_inv; driveReset_b == !systemBusReset; endproperty
  a_rst_inv: assert property (p_rst_inv) else $error("drive reset not inverse");
  property p_ack_req; $fell(primaryDmaAck_b) |-> $past(primaryDmaRequest); endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_upper; cardUpperAddr == 3'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper address not low");
  // Low byte must be what stood on the bus at the rising edge
  property p_rd_cap;
    $rose(primaryReadStrobe_b) |-> priRspValid && ((priRspData ^ $past(primaryDiskDataBusIn)) & 16'h00ff) == 16'h0000;
  endproperty
  a_rd_cap: assert property (p_rd_cap) else $error("read data not captured");
  property p_stretch; !primaryReadStrobe_b && !primaryChannelReady && primaryDmaAck_b |=> !primaryReadStrobe_b; endproperty
  a_stretch: assert property (p_stretch) else $error("strobe not stretched");
  property p_oe; !primaryReadStrobe_b |-> primaryDiskDataBusOe_b; endproperty
  a_oe: assert property (p_oe) else $error("host drives bus in read");
  property p_wr_oe; !primaryWriteStrobe_b |-> !primaryDiskDataBusOe_b; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("host not driving bus in write");
  property p_fast; priFastDmaAllowed == (priUltraDmaWanted && primaryCableSense); endproperty
  a_fast: assert property (p_fast) else $error("fast dma gate wrong");
  property p_irq; priIrqOut == primaryIrq14; endproperty
  a_irq: assert property (p_irq) else $error("irq not passed");
endmodule
bind ahp_ata_host_channel_port ahp_host_port_checker chk (.*);
`default_nettype wire

// ---- ahp_drive_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Behavioural drive on one channel
// ****************************************
module ahp_drive_model
  import ahp_pkg::*;
(
  // Clock and bench commands
  input wire logic clock,
  input wire logic [3:0] slow,
  input wire logic dmaWanted,
  input wire logic irqWanted,
  // Cable
  input wire logic [ahp_pkg::DATA_W-1:0] hostBus,
  output logic [ahp_pkg::DATA_W-1:0] driveBus,
  input wire logic [ahp_pkg::ADDR_W-1:0] regSel,
  input wire logic ctlSel_b,
  input wire logic rdStrobe_b,
  input wire logic wrStrobe_b,
  input wire logic dmaAck_b,
  output logic ready,
  output logic dmaReq,
  output logic irq
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [3:0] cnt = 4'h0;
  logic [3:0] idx;
  logic busy = 1'b0;
  // DMA words live in slot 15, shared with command block register 7
  assign idx = dmaAck_b ? {ctlSel_b, regSel} : 4'hf;
  assign dmaReq = dmaWanted;
  assign irq = irqWanted;
  // Card pin tied low, so this drive answers as master; no slave modelled
  // Released bus shows a changed value, never the stale word
  assign driveBus = !rdStrobe_b ? mem[idx] : ~last;
  assign ready = !(busy && cnt != 4'h0) || !dmaAck_b;
  // Trailing edge of the write strobe latches
  always @(posedge wrStrobe_b)
    mem[idx] <= hostBus;
  // Not-ready span counted from the strobe
  always @(posedge clock)
  begin
    if (!rdStrobe_b)
      last <= mem[idx];
    busy <= !(rdStrobe_b && wrStrobe_b);
    if (rdStrobe_b && wrStrobe_b)
      cnt <= slow;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) \
  n_checks++; \
  if ((g) !== (e)) \
  begin \
    fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); \
  end
module tb_top;
  import ahp_pkg::*;
  // ****************************************
  // Signals, both channels run the same traffic
  // ****************************************
  logic clock = 1'b0, rst_b = 1'b0, systemBusReset = 1'b1, priReqValid = 1'b0, priReqWrite = 1'b0;
  logic priReqControlBlock = 1'b0, priUltraDmaWanted = 1'b0, secUltraDmaWanted = 1'b0, dmaOn = 1'b0;
  logic primaryCableSense = 1'b0, secondaryCableSense = 1'b0, irqOn = 1'b0;
  ahp_kind_t priReqKind = AHP_KIND_REG;
  logic [2:0] priReqAddr = 3'h0;
  logic [3:0] slow = 4'h0;
  logic [15:0] priReqData = 16'h0000, rdP, rdS;
  int fail_count = 0, n_checks = 0;
  int hiEnCnt = 0;
  wire secReqValid = priReqValid, secReqWrite = priReqWrite, secReqControlBlock = priReqControlBlock;
  wire ahp_kind_t secReqKind = priReqKind;
  wire [2:0] secReqAddr = priReqAddr;
  wire [15:0] secReqData = priReqData;
  logic priReqReady, priRspValid, priFastDmaAllowed, priIrqOut, cardEnableLow_b, cardEnableHigh_b, driveReset_b;
  logic secReqReady, secRspValid, secFastDmaAllowed, secIrqOut, primaryDiskDataBusOe_b, secondaryDiskDataBusOe_b;
  logic [15:0] priRspData, secRspData, primaryDiskDataBusIn, primaryDiskDataBusOut;
  logic [15:0] secondaryDiskDataBusIn, secondaryDiskDataBusOut;
  logic [2:0] primaryRegisterSelect, secondaryRegisterSelect, cardUpperAddr;
  logic primaryCommandBlockSelect_b, primaryControlBlockSelect_b, primaryReadStrobe_b, primaryWriteStrobe_b;
  logic primaryChannelReady, primaryDmaRequest, primaryDmaAck_b, primaryIrq14;
  logic secondaryCommandBlockSelect_b, secondaryControlBlockSelect_b, secondaryReadStrobe_b;
  logic secondaryWriteStrobe_b, secondaryChannelReady, secondaryDmaRequest, secondaryDmaAck_b, secondaryIrq15;
  ahp_ata_host_channel_port uut (.*);
  ahp_drive_model pDrv (.clock, .slow, .dmaWanted(dmaOn), .irqWanted(irqOn), .hostBus(primaryDiskDataBusOut),
    .driveBus(primaryDiskDataBusIn), .regSel(primaryRegisterSelect), .ctlSel_b(primaryControlBlockSelect_b),
    .rdStrobe_b(primaryReadStrobe_b), .wrStrobe_b(primaryWriteStrobe_b), .dmaAck_b(primaryDmaAck_b),
    .ready(primaryChannelReady), .dmaReq(primaryDmaRequest), .irq(primaryIrq14));
  ahp_drive_model sDrv (.clock, .slow, .dmaWanted(dmaOn), .irqWanted(irqOn), .hostBus(secondaryDiskDataBusOut),
    .driveBus(secondaryDiskDataBusIn), .regSel(secondaryRegisterSelect), .ctlSel_b(secondaryControlBlockSelect_b),
    .rdStrobe_b(secondaryReadStrobe_b), .wrStrobe_b(secondaryWriteStrobe_b), .dmaAck_b(secondaryDmaAck_b),
    .ready(secondaryChannelReady), .dmaReq(secondaryDmaRequest), .irq(secondaryIrq15));
  always #5 clock = ~clock;
  // Odd-byte card enable, counted per cycle so tasks can take differences
  always @(negedge clock)
    if (cardEnableHigh_b === 1'b0)
      hiEnCnt++;
  // One request, held until taken; reads wait for the answer
  task automatic xfer(input logic w, input ahp_kind_t k, input logic c, input logic [2:0] a, input logic [15:0] d);
    int t;
    rdP = 16'hxxxx;
    rdS = 16'hxxxx;
    @(negedge clock);
    {priReqValid, priReqWrite, priReqKind, priReqControlBlock, priReqAddr, priReqData} = {1'b1, w, k, c, a, d};
    for (t = 0; t < 50 && !(priReqReady && secReqReady); t++)
      @(negedge clock);
    if (t == 50)
      fail_count++;
    @(negedge clock);
    priReqValid = 1'b0;
    for (t = 0; t < 60 && !w && priRspValid !== 1'b1; t++)
      @(negedge clock);
    if (t == 60)
      fail_count++;
    rdP = priRspData;
    rdS = secRspData;
  endtask
  task automatic t_regs();
    int n0;
    n0 = hiEnCnt;
    for (int i = 0; i < 16; i++)
      xfer(1'b1, AHP_KIND_REG, i[3], i[2:0], {8'hee, i[3:0], ~i[3:0]});
    for (int i = 0; i < 16; i++)
    begin
      slow = i[0] ? 4'hc : 4'h0;
      xfer(1'b0, AHP_KIND_REG, i[3], i[2:0], 16'h0000);
      `CHK("regP", {8'h00, i[3:0], ~i[3:0]}, rdP)
      `CHK("regS", {8'h00, i[3:0], ~i[3:0]}, rdS)
      `CHK("regHi", 8'h00, pDrv.mem[{~i[3], i[2:0]}][15:8])
    end
    slow = 4'h0;
    `CHK("regHighEn", 0, hiEnCnt - n0)
  endtask
  task automatic t_word();
    int n0;
    n0 = hiEnCnt;
    xfer(1'b1, AHP_KIND_PIO_DATA, 1'b0, 3'h0, 16'h1234);
    xfer(1'b0, AHP_KIND_PIO_DATA, 1'b0, 3'h0, 16'h0000);
    // Command block, address 0 lands in slot 8 of the model
    `CHK("evenByte", 8'h34, pDrv.mem[8][7:0])
    `CHK("oddByte", 8'h12, pDrv.mem[8][15:8])
    `CHK("wordP", 16'h1234, rdP)
    `CHK("wordS", 16'h1234, rdS)
    `CHK("wordHighEn", 2 * (PIO_ACTIVE_CYC + 1), hiEnCnt - n0)
  endtask
  task automatic t_dma();
    @(negedge clock);
    priReqKind = AHP_KIND_DMA;
    repeat (3) @(negedge clock);
    `CHK("dmaRefused", 1'b0, priReqReady)
    `CHK("dmaNoAck", 1'b1, primaryDmaAck_b)
    dmaOn = 1'b1;
    xfer(1'b1, AHP_KIND_DMA, 1'b0, 3'h0, 16'hbeef);
    xfer(1'b0, AHP_KIND_DMA, 1'b0, 3'h0, 16'h0000);
    `CHK("dmaP", 16'hbeef, rdP)
    `CHK("dmaS", 16'hbeef, rdS)
    dmaOn = 1'b0;
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clock);
      {priUltraDmaWanted, primaryCableSense, secUltraDmaWanted, secondaryCableSense} = {i[1:0], ~i[1:0]};
      irqOn = i[0];
      systemBusReset = i[1];
      @(negedge clock);
      `CHK("fastP", i[1] & i[0], priFastDmaAllowed)
      `CHK("fastS", ~i[1] & ~i[0], secFastDmaAllowed)
      `CHK("irq", {i[0], i[0]}, {priIrqOut, secIrqOut})
      `CHK("driveRst", ~i[1], driveReset_b)
      `CHK("upper", 3'h0, cardUpperAddr)
    end
    systemBusReset = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    systemBusReset = 1'b0;
    t_regs();
    t_word();
    t_dma();
    t_pins();
    end_sim();
  end
  // Watchdog, about fifteen times the expected run
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
